// ==== design/bwr_pkg.sv ====
package bwr_pkg;

    // clock and derived timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SECOND_NS = 1_000_000_000;
    localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned DEBOUNCE_US = 10_000;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned RST_STRETCH_NS = 1000;
    localparam logic [7:0] RST_STRETCH_CYCLES =
        8'((RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] OVERRIDE_SEC = 4'h4;
    // one extra tick because the first tick may land right after the handle opens
    localparam logic [3:0] OVERRIDE_TICKS = OVERRIDE_SEC + 4'h1;

    // watchdog period choices in seconds
    localparam logic [7:0] WD_SEC_SEL0 = 8'h02;
    localparam logic [7:0] WD_SEC_SEL1 = 8'h0A;
    localparam logic [7:0] WD_SEC_SEL2 = 8'h32;
    localparam logic [7:0] WD_SEC_SEL3 = 8'hFF;

    // register byte offsets
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_TRIGGER = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;

    // control fields
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_SEL_LSB = 0;
    localparam int unsigned CTRL_SWAP_BIT = 2;
    localparam int unsigned CTRL_RSTSW_DIS_BIT = 3;
    localparam int unsigned CTRL_HANDLE_DIS_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // status and interrupt fields
    localparam int unsigned STAT_W = 4;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_PWRBTN_BIT = 0;
    localparam int unsigned IRQ_OVERRIDE_BIT = 1;
    localparam int unsigned IRQ_WAKE_BIT = 2;
    localparam int unsigned IRQ_ARMED_BIT = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // debounced input lanes
    localparam int unsigned IN_HANDLE = 0;
    localparam int unsigned IN_RSTSW = 1;
    localparam int unsigned IN_N = 2;

    typedef enum logic [2:0] {
        PWR_BOOT,
        PWR_S0,
        PWR_S5_HELD,
        PWR_S5,
        PWR_S5_REOPEN
    } bwr_pwr_t;

    function automatic logic [7:0] bwr_wd_secs(input logic [1:0] sel);
        logic [7:0] secs;
        secs = WD_SEC_SEL0;
        case (sel)
            2'h1: secs = WD_SEC_SEL1;
            2'h2: secs = WD_SEC_SEL2;
            2'h3: secs = WD_SEC_SEL3;
            default: secs = WD_SEC_SEL0;
        endcase
        return secs;
    endfunction

endpackage

// ==== design/bwr_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module bwr_debounce #(
    parameter int unsigned CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic raw_i,
    output logic level_o,
    output logic valid_o
);

    logic last;
    logic [31:0] cnt;
    logic next_last;
    logic [31:0] next_cnt;
    logic next_level;
    logic next_valid;

    // level follows raw only after it held still a whole window
    always_comb
    begin
        next_last = raw_i;
        next_cnt = cnt;
        next_level = level_o;
        next_valid = valid_o;
        if (raw_i != last)
        begin
            next_cnt = 32'h0000_0000;
        end
        else if (cnt == CYCLES - 1)
        begin
            next_level = last;
            next_valid = 1'b1;
            next_cnt = 32'h0000_0000;
        end
        else
        begin
            next_cnt = cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            last <= 1'b0;
            cnt <= 32'h0000_0000;
            level_o <= 1'b0;
            valid_o <= 1'b0;
        end
        else
        begin
            last <= next_last;
            cnt <= next_cnt;
            level_o <= next_level;
            valid_o <= next_valid;
        end
    end

endmodule
`default_nettype wire

// ==== design/bwr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module bwr_top #(
    parameter int unsigned TICK_CYCLES = bwr_pkg::TICK_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = bwr_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic handle_open_i,
    input wire logic reset_switch_i,
    input wire logic backplane_reset_in_n_i,
    input wire logic supplies_ok_i,
    output logic sys_reset_o,
    output logic pwrbtn_event_o,
    output logic soft_off_o,
    output logic power_good_green_o,
    output logic power_good_yellow_o,
    output logic irq_o
);

    logic [bwr_pkg::IN_N-1:0] raw_in;
    logic [bwr_pkg::IN_N-1:0] db_level;
    logic [bwr_pkg::IN_N-1:0] db_valid;

    // both front-panel contacts get the same filter
    assign raw_in[bwr_pkg::IN_HANDLE] = handle_open_i;
    assign raw_in[bwr_pkg::IN_RSTSW] = reset_switch_i;
    generate
        for (genvar g = 0; g < bwr_pkg::IN_N; g++)
        begin : g_db
            bwr_debounce #(
                .CYCLES(DEBOUNCE_CYCLES)
            ) u_db (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .raw_i(raw_in[g]),
                .level_o(db_level[g]),
                .valid_o(db_valid[g])
            );
        end
    endgenerate

    logic [31:0] div_cnt;
    logic tick;
    logic blink;
    logic [bwr_pkg::CTRL_W-1:0] ctrl;
    logic armed;
    logic [8:0] wd_secs;
    logic wd_timeout;
    logic hdl_prev;
    logic [3:0] hdl_secs;
    bwr_pkg::bwr_pwr_t pwr_state;
    logic [7:0] rst_cnt;
    logic [bwr_pkg::IRQ_W-1:0] irq_stat;
    logic [bwr_pkg::IRQ_W-1:0] irq_mask;

    logic [31:0] next_div_cnt;
    logic next_tick;
    logic next_blink;
    logic [bwr_pkg::CTRL_W-1:0] next_ctrl;
    logic next_armed;
    logic [8:0] next_wd_secs;
    logic next_wd_timeout;
    logic [3:0] next_hdl_secs;
    bwr_pkg::bwr_pwr_t next_pwr_state;
    logic [7:0] next_rst_cnt;
    logic [bwr_pkg::IRQ_W-1:0] next_irq_stat;
    logic [bwr_pkg::IRQ_W-1:0] next_irq_mask;
    logic next_sys_reset;
    logic next_pwrbtn;
    logic next_green;
    logic next_yellow;
    logic next_wait;
    logic [31:0] next_rdata;

    logic acc_wr;
    logic trig;
    logic handle_fn;
    logic rstsw_fn;
    logic hdl_phys_open;
    logic open_edge;
    logic rst_src;
    logic [8:0] wd_limit;
    logic [bwr_pkg::IRQ_W-1:0] irq_ev;
    logic [bwr_pkg::IRQ_W-1:0] irq_clr;
    logic [1:0] wr_sel;

    // a write is taken at the edge where waitrequest is seen low
    assign acc_wr = avs_write_i && !avs_waitrequest_o;
    assign trig = acc_wr && (avs_address_i == bwr_pkg::ADDR_TRIGGER);
    assign wr_sel = avs_writedata_i[bwr_pkg::CTRL_SEL_LSB +: 2];

    // firmware role swap and disables, gated until filters settle
    always_comb
    begin
        handle_fn = ctrl[bwr_pkg::CTRL_SWAP_BIT] ? db_level[bwr_pkg::IN_RSTSW]
                                                 : db_level[bwr_pkg::IN_HANDLE];
        rstsw_fn = ctrl[bwr_pkg::CTRL_SWAP_BIT] ? db_level[bwr_pkg::IN_HANDLE]
                                                : db_level[bwr_pkg::IN_RSTSW];
        handle_fn = handle_fn && !ctrl[bwr_pkg::CTRL_HANDLE_DIS_BIT] && (&db_valid);
        rstsw_fn = rstsw_fn && !ctrl[bwr_pkg::CTRL_RSTSW_DIS_BIT] && (&db_valid);
        hdl_phys_open = db_level[bwr_pkg::IN_HANDLE] && db_valid[bwr_pkg::IN_HANDLE];
        open_edge = handle_fn && !hdl_prev;
    end

    // seconds tick; shared by watchdog, override timer and blink
    always_comb
    begin
        next_div_cnt = div_cnt + 32'h0000_0001;
        next_tick = 1'b0;
        next_blink = blink;
        if (div_cnt == TICK_CYCLES - 1)
        begin
            next_div_cnt = 32'h0000_0000;
            next_tick = 1'b1;
            next_blink = !blink;
        end
    end

    // watchdog: idle until first trigger, then never disarmed
    always_comb
    begin
        wd_limit = {1'b0, bwr_pkg::bwr_wd_secs(ctrl[bwr_pkg::CTRL_SEL_LSB +: 2])} + 9'h001;
        next_armed = armed;
        next_wd_secs = wd_secs;
        next_wd_timeout = 1'b0;
        if (trig)
        begin
            next_armed = 1'b1;
            next_wd_secs = 9'h000;
        end
        else if (armed && tick)
        begin
            next_wd_secs = wd_secs + 9'h001;
            if (next_wd_secs >= wd_limit)
            begin
                next_wd_timeout = 1'b1;
                next_wd_secs = 9'h000;
            end
        end
    end

    // reset sources merged and stretched to a clean pulse
    always_comb
    begin
        rst_src = wd_timeout || rstsw_fn || !backplane_reset_in_n_i;
        next_rst_cnt = rst_cnt;
        if (rst_src)
        begin
            next_rst_cnt = bwr_pkg::RST_STRETCH_CYCLES;
        end
        else if (rst_cnt != 8'h00)
        begin
            next_rst_cnt = rst_cnt - 8'h01;
        end
        next_sys_reset = rst_src || (rst_cnt != 8'h00);
    end

    // power state: boot check, long-press override, wake by reopen
    always_comb
    begin
        next_pwr_state = pwr_state;
        next_hdl_secs = hdl_secs;
        irq_ev = '0;
        if (!handle_fn)
        begin
            next_hdl_secs = 4'h0;
        end
        else if (tick && hdl_secs != bwr_pkg::OVERRIDE_TICKS)
        begin
            next_hdl_secs = hdl_secs + 4'h1;
        end
        next_pwrbtn = open_edge && (pwr_state != bwr_pkg::PWR_BOOT);
        irq_ev[bwr_pkg::IRQ_PWRBTN_BIT] = next_pwrbtn;
        irq_ev[bwr_pkg::IRQ_ARMED_BIT] = trig && !armed;
        case (pwr_state)
            bwr_pkg::PWR_BOOT:
                if (&db_valid)
                begin
                    next_pwr_state = handle_fn ? bwr_pkg::PWR_S5_HELD : bwr_pkg::PWR_S0;
                end
            bwr_pkg::PWR_S0:
                if (next_hdl_secs == bwr_pkg::OVERRIDE_TICKS)
                begin
                    next_pwr_state = bwr_pkg::PWR_S5_HELD;
                    irq_ev[bwr_pkg::IRQ_OVERRIDE_BIT] = 1'b1;
                end
            bwr_pkg::PWR_S5_HELD:
                if (!handle_fn)
                begin
                    next_pwr_state = bwr_pkg::PWR_S5;
                end
            bwr_pkg::PWR_S5:
                if (open_edge)
                begin
                    next_pwr_state = bwr_pkg::PWR_S5_REOPEN;
                end
            bwr_pkg::PWR_S5_REOPEN:
                if (!handle_fn)
                begin
                    next_pwr_state = bwr_pkg::PWR_S0;
                    irq_ev[bwr_pkg::IRQ_WAKE_BIT] = 1'b1;
                end
            default:
                next_pwr_state = bwr_pkg::PWR_BOOT;
        endcase
        next_yellow = hdl_phys_open && blink;
        next_green = supplies_ok_i && !next_sys_reset && !hdl_phys_open
                     && (next_pwr_state == bwr_pkg::PWR_S0);
    end

    // register file and avalon handshake; one wait state per access
    always_comb
    begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        irq_clr = '0;
        if (acc_wr && avs_byteenable_i[0])
        begin
            if (avs_address_i == bwr_pkg::ADDR_CTRL)
            begin
                next_ctrl = avs_writedata_i[bwr_pkg::CTRL_W-1:0];
            end
            else if (avs_address_i == bwr_pkg::ADDR_IRQ_STATUS)
            begin
                irq_clr = avs_writedata_i[bwr_pkg::IRQ_W-1:0];
            end
            else if (avs_address_i == bwr_pkg::ADDR_IRQ_MASK)
            begin
                next_irq_mask = avs_writedata_i[bwr_pkg::IRQ_W-1:0];
            end
        end
        // set wins over a clear landing in the same cycle
        next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
        next_wait = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
        next_rdata = avs_readdata_o;
        if (avs_read_i && avs_waitrequest_o)
        begin
            next_rdata = 32'h0000_0000;
            if (avs_address_i == bwr_pkg::ADDR_CTRL)
            begin
                next_rdata[bwr_pkg::CTRL_W-1:0] = ctrl;
            end
            else if (avs_address_i == bwr_pkg::ADDR_STATUS)
            begin
                next_rdata[bwr_pkg::STAT_W-1:0] = {rstsw_fn, hdl_phys_open, soft_off_o, armed};
            end
            else if (avs_address_i == bwr_pkg::ADDR_IRQ_STATUS)
            begin
                next_rdata[bwr_pkg::IRQ_W-1:0] = irq_stat;
            end
            else if (avs_address_i == bwr_pkg::ADDR_IRQ_MASK)
            begin
                next_rdata[bwr_pkg::IRQ_W-1:0] = irq_mask;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            div_cnt <= 32'h0000_0000;
            tick <= 1'b0;
            blink <= 1'b0;
            ctrl <= bwr_pkg::CTRL_RESET;
            armed <= 1'b0;
            wd_secs <= 9'h000;
            wd_timeout <= 1'b0;
            hdl_prev <= 1'b0;
            hdl_secs <= 4'h0;
            pwr_state <= bwr_pkg::PWR_BOOT;
            rst_cnt <= 8'h00;
            irq_stat <= bwr_pkg::IRQ_RESET;
            irq_mask <= bwr_pkg::IRQ_RESET;
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
            sys_reset_o <= 1'b0;
            pwrbtn_event_o <= 1'b0;
            soft_off_o <= 1'b0;
            power_good_green_o <= 1'b0;
            power_good_yellow_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
            blink <= next_blink;
            ctrl <= next_ctrl;
            armed <= next_armed;
            wd_secs <= next_wd_secs;
            wd_timeout <= next_wd_timeout;
            hdl_prev <= handle_fn;
            hdl_secs <= next_hdl_secs;
            pwr_state <= next_pwr_state;
            rst_cnt <= next_rst_cnt;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            avs_readdata_o <= next_rdata;
            avs_waitrequest_o <= next_wait;
            sys_reset_o <= next_sys_reset;
            pwrbtn_event_o <= next_pwrbtn;
            soft_off_o <= (next_pwr_state != bwr_pkg::PWR_S0)
                          && (next_pwr_state != bwr_pkg::PWR_BOOT);
            power_good_green_o <= next_green;
            power_good_yellow_o <= next_yellow;
            irq_o <= |(next_irq_stat & next_irq_mask);
        end
    end

    // checks on the logic above
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_wd_idle_quiet: assert property (!armed |-> !next_wd_timeout)
        else $error("watchdog expired while idle");
    a_wd_arms: assert property (trig && !armed |=> armed && wd_secs == 9'h000)
        else $error("trigger did not arm watchdog");
    a_wd_stays: assert property (armed |=> armed)
        else $error("watchdog left armed state");
    a_wd_reset_out: assert property (wd_timeout |=> sys_reset_o [*8])
        else $error("timeout gave no reset");
    a_wd_period: assert property (armed && tick && !trig |->
        next_wd_timeout == (wd_secs >= {1'b0, bwr_pkg::bwr_wd_secs(ctrl[1:0])}))
        else $error("timeout at wrong second count");
    a_sel_write: assert property (acc_wr && avs_byteenable_i[0]
        && avs_address_i == bwr_pkg::ADDR_CTRL |=> ctrl[1:0] == $past(wr_sel))
        else $error("period selection not stored");
    a_bp_reset: assert property (!backplane_reset_in_n_i |=> sys_reset_o)
        else $error("backplane reset ignored");
    a_green_cond: assert property (power_good_green_o |->
        $past(supplies_ok_i) && !sys_reset_o)
        else $error("green with bad supply or reset");
    a_btn_single: assert property (pwrbtn_event_o |=> !pwrbtn_event_o)
        else $error("power button pulse too long");
    a_ovr_s5: assert property (irq_ev[bwr_pkg::IRQ_OVERRIDE_BIT] |=> soft_off_o)
        else $error("override did not enter soft off");
    a_yellow_open: assert property (power_good_yellow_o |-> !power_good_green_o)
        else $error("yellow and green together");
    a_bus_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus wait state count wrong");

    c_wd_timeout: cover property (armed ##1 wd_timeout);
    c_override: cover property (irq_ev[bwr_pkg::IRQ_OVERRIDE_BIT]);
    c_wake: cover property (irq_ev[bwr_pkg::IRQ_WAKE_BIT]);
    c_pwrbtn: cover property (pwrbtn_event_o);

endmodule
`default_nettype wire

// ==== verif/bwr_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// front panel switches, backplane reset line and supply monitor
module bwr_panel_model (
    input wire logic clk_i,
    input wire logic open_cmd_i,
    input wire logic press_cmd_i,
    input wire logic bp_cmd_i,
    input wire logic pwr_cmd_i,
    output wire logic handle_open_o,
    output wire logic reset_switch_o,
    output wire logic backplane_reset_in_n_o,
    output wire logic supplies_ok_o
);
    logic [1:0] last = 2'b00;
    logic [1:0] bounce = 2'h0;
    // every handle or switch actuation chatters for three cycles, never stable long enough to pass
    always @(posedge clk_i)
    begin
        last <= {open_cmd_i, press_cmd_i};
        if ({open_cmd_i, press_cmd_i} != last)
            bounce <= 2'h3;
        else if (bounce != 2'h0)
            bounce <= bounce - 2'h1;
    end
    // contacts show the inverted level on odd bounce steps
    assign handle_open_o = open_cmd_i ^ bounce[0];
    assign reset_switch_o = press_cmd_i ^ bounce[0];
    assign backplane_reset_in_n_o = ~bp_cmd_i; // pulled to ground when active
    assign supplies_ok_o = pwr_cmd_i;
endmodule
`default_nettype wire

// ==== verif/bwr_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module bwr_top_bench;
    localparam int TICK = 20;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o, rd;
    logic avs_waitrequest_o, handle_open_i, reset_switch_i, backplane_reset_in_n_i;
    logic supplies_ok_i, sys_reset_o, pwrbtn_event_o, soft_off_o, irq_o;
    logic power_good_green_o, power_good_yellow_o, yel_prev;
    logic open_cmd = 1'b0;
    logic press_cmd = 1'b0;
    logic bp_cmd = 1'b0;
    logic pwr_cmd = 1'b1;
    int err_count = 0;
    int total_checks = 0;
    int rst_cnt = 0;
    int pb_cnt = 0;
    int yel_cnt = 0;
    int n, c;

    bwr_top #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(4)) u_bwr_top (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .handle_open_i(handle_open_i), .reset_switch_i(reset_switch_i),
        .backplane_reset_in_n_i(backplane_reset_in_n_i), .supplies_ok_i(supplies_ok_i),
        .sys_reset_o(sys_reset_o), .pwrbtn_event_o(pwrbtn_event_o), .soft_off_o(soft_off_o),
        .power_good_green_o(power_good_green_o),
        .power_good_yellow_o(power_good_yellow_o), .irq_o(irq_o));

    bwr_panel_model u_bwr_panel_model (
        .clk_i(clk_i), .open_cmd_i(open_cmd), .press_cmd_i(press_cmd), .bp_cmd_i(bp_cmd),
        .pwr_cmd_i(pwr_cmd), .handle_open_o(handle_open_i), .reset_switch_o(reset_switch_i),
        .backplane_reset_in_n_o(backplane_reset_in_n_i), .supplies_ok_o(supplies_ok_i));

    always #10 clk_i = ~clk_i;

    // edge counters; pre-edge values, so no race with the design's updates
    always @(posedge clk_i)
    begin
        yel_prev <= power_good_yellow_o;
        if (sys_reset_o === 1'b1) rst_cnt++;
        if (pwrbtn_event_o === 1'b1) pb_cnt++;
        if (power_good_yellow_o !== yel_prev) yel_cnt++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // one request held until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (avs_waitrequest_o !== 1'b0 && k < 20);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (k >= 20) check(32'h1, 32'h0);
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic wait_rst(output int k);
        k = 0;
        while (sys_reset_o !== 1'b1 && k < 400)
        begin
            @(posedge clk_i);
            k++;
        end
    endtask

    // system reset loop-back, then let the debouncers settle
    task automatic reset_dut();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // sized from the test length with generous margin
    initial
    begin
        #(20 * 20000);
        err_count++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rdchk(bwr_pkg::ADDR_CTRL, 32'h0);
        rdchk(bwr_pkg::ADDR_IRQ_MASK, 32'h0);
        bus(1'b1, 5'h14, 32'hFF);
        rdchk(5'h14, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, bwr_pkg::ADDR_CTRL, 32'(s));
            rdchk(bwr_pkg::ADDR_CTRL, 32'(s));
        end
        c = rst_cnt;
        repeat (10 * TICK) @(posedge clk_i);
        check(32'(rst_cnt - c), 32'h0);
        rdchk(bwr_pkg::ADDR_STATUS, 32'h0);
        $display("idle and register test done");
        bus(1'b1, bwr_pkg::ADDR_CTRL, 32'h1);
        bus(1'b1, bwr_pkg::ADDR_TRIGGER, 32'h1);
        repeat (6 * TICK) @(posedge clk_i);
        check(32'(rst_cnt - c), 32'h0);
        bus(1'b1, bwr_pkg::ADDR_CTRL, 32'h0);
        wait_rst(n);
        check_bit(n <= TICK, 1'b1);
        bus(1'b0, bwr_pkg::ADDR_STATUS, 32'h0);
        check_bit(rd[0], 1'b1);
        reset_dut();
        rdchk(bwr_pkg::ADDR_STATUS, 32'h0);
        c = rst_cnt;
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, bwr_pkg::ADDR_TRIGGER, 32'h1);
            repeat (TICK) @(posedge clk_i);
        end
        check(32'(rst_cnt - c), 32'h0);
        rdchk(bwr_pkg::ADDR_IRQ_STATUS, 32'h8);
        bus(1'b1, bwr_pkg::ADDR_TRIGGER, 32'h1);
        wait_rst(n);
        check_bit(n >= 2 * TICK - 2 && n <= 3 * TICK + 4, 1'b1);
        reset_dut();
        $display("watchdog test done");
        for (int src = 0; src < 2; src++)
        begin
            if (src == 0) bp_cmd <= 1'b1;
            else press_cmd <= 1'b1;
            wait_rst(n);
            check_bit(n <= 12, 1'b1);
            bp_cmd <= 1'b0;
            press_cmd <= 1'b0;
            repeat (50) @(posedge clk_i);
            check_bit(sys_reset_o, 1'b1);
            repeat (40) @(posedge clk_i);
        end
        c = rst_cnt;
        bus(1'b1, bwr_pkg::ADDR_CTRL, 32'h08);
        press_cmd <= 1'b1;
        repeat (30) @(posedge clk_i);
        check(32'(rst_cnt - c), 32'h0);
        // let the switch filter fall before the swap, or the swap itself reads as a press
        press_cmd <= 1'b0;
        repeat (20) @(posedge clk_i);
        c = pb_cnt;
        bus(1'b1, bwr_pkg::ADDR_CTRL, 32'h04);
        press_cmd <= 1'b1;
        repeat (20) @(posedge clk_i);
        check(32'(pb_cnt - c), 32'h1);
        press_cmd <= 1'b0;
        repeat (20) @(posedge clk_i);
        bus(1'b1, bwr_pkg::ADDR_CTRL, 32'h0);
        reset_dut();
        $display("reset source test done");
        check_bit(power_good_green_o, 1'b1);
        bus(1'b1, bwr_pkg::ADDR_IRQ_MASK, 32'h1);
        c = pb_cnt;
        n = yel_cnt;
        open_cmd <= 1'b1;
        repeat (3 * TICK + 10) @(posedge clk_i);
        check(32'(pb_cnt - c), 32'h1);
        check_bit(soft_off_o, 1'b0);
        check_bit(irq_o, 1'b1);
        check_bit(yel_cnt - n >= 2, 1'b1);
        check_bit(power_good_green_o, 1'b0);
        repeat (3 * TICK) @(posedge clk_i);
        check_bit(soft_off_o, 1'b1);
        rdchk(bwr_pkg::ADDR_IRQ_STATUS, 32'h3);
        bus(1'b1, bwr_pkg::ADDR_IRQ_STATUS, 32'hF);
        repeat (2) @(posedge clk_i);
        check_bit(irq_o, 1'b0);
        open_cmd <= 1'b0;
        repeat (20) @(posedge clk_i);
        open_cmd <= 1'b1;
        repeat (20) @(posedge clk_i);
        open_cmd <= 1'b0;
        repeat (30) @(posedge clk_i);
        check_bit(soft_off_o, 1'b0);
        bus(1'b0, bwr_pkg::ADDR_IRQ_STATUS, 32'h0);
        check_bit(rd[2], 1'b1);
        check_bit(power_good_green_o, 1'b1);
        pwr_cmd <= 1'b0;
        repeat (3) @(posedge clk_i);
        check_bit(power_good_green_o, 1'b0);
        pwr_cmd <= 1'b1;
        $display("handle test done");
        // handle function disabled: opening gives no button event, status still sees it
        bus(1'b1, bwr_pkg::ADDR_CTRL, 32'h10);
        c = pb_cnt;
        open_cmd <= 1'b1;
        repeat (30) @(posedge clk_i);
        check(32'(pb_cnt - c), 32'h0);
        rdchk(bwr_pkg::ADDR_STATUS, 32'h4);
        reset_dut();
        repeat (10) @(posedge clk_i);
        check_bit(soft_off_o, 1'b1);
        rdchk(bwr_pkg::ADDR_STATUS, 32'h6);
        $display("open handle power-up test done");
        stop_test();
    end
endmodule
`default_nettype wire
